// file: rtl/mcrb_pkg.sv
// Constants and types for the main clock, real-time tick and tone block.
// Assumes one clock: the oscillator clock, also used by the register bus.
package mcrb_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] MCRB_IDX_CCS = 8'h2c;
  localparam logic [7:0] MCRB_IDX_TONE = 8'h2d;
  localparam logic [7:0] MCRB_IDX_IRQ_STAT = 8'h2e;
  localparam logic [7:0] MCRB_IDX_IRQ_MASK = 8'h2f;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int MCRB_CCS_CLKOUT_BIT = 7;
  localparam int MCRB_CCS_CP_LSB = 5;
  localparam int MCRB_CCS_SMS_BIT = 4;
  localparam int MCRB_CCS_TB_LSB = 2;
  localparam int MCRB_CCS_IE_BIT = 1;
  localparam int MCRB_CCS_FLAG_BIT = 0;
  localparam logic [7:0] MCRB_CCS_RST = 8'h00;
  localparam logic [1:0] MCRB_TONE_RST = 2'h0;
  localparam logic [0:0] MCRB_IRQ_RST = 1'h0;

  // ************************************************************
  // Timing counts in oscillator-clock cycles
  // ************************************************************
  localparam int MCRB_TICK_P0 = 16000;
  localparam int MCRB_TICK_P1 = 32000;
  localparam int MCRB_TICK_P2 = 80000;
  localparam int MCRB_TICK_P3 = 200000;
  // Half periods of the tone for an 8 MHz oscillator: 2 kHz, 1 kHz, 500 Hz
  localparam int MCRB_TONE_H1 = 2000;
  localparam int MCRB_TONE_H2 = 4000;
  localparam int MCRB_TONE_H3 = 8000;

  // ************************************************************
  // Power states
  // ************************************************************
  typedef enum logic [1:0] {
    MCRB_RUN = 2'b00,
    MCRB_ACT_HALT = 2'b01,
    MCRB_FULL_HALT = 2'b10
  } mcrb_pwr_t;

endpackage : mcrb_pkg

// file: rtl/mcrb_tone_if.sv
// Link between the control logic and the tone generator.
// Assumes both ends share the oscillator clock.
`timescale 1ns/1ns
interface mcrb_tone_if;
  logic [1:0] tone_code;
  logic run;
  logic level;
  modport ctrl (output tone_code, output run, input level);
  modport gen (input tone_code, input run, output level);
endinterface : mcrb_tone_if

// file: rtl/mcrb_tone.sv
// Tone generator: square wave of about half duty selected by a 2-bit code.
// Assumes the oscillator clock; the run input stops it in full halt.
`timescale 1ns/1ns
module mcrb_tone
  import mcrb_pkg::*;
#(
  parameter int TONE_H3 = MCRB_TONE_H3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control side
  mcrb_tone_if.gen tif
);

  logic [13:0] div_reg;
  logic [13:0] half_cnt;
  logic level_reg;

  always_comb begin
    case (tif.tone_code)
      2'h1: half_cnt = 14'(MCRB_TONE_H1 - 1);
      2'h2: half_cnt = 14'(MCRB_TONE_H2 - 1);
      2'h3: half_cnt = 14'(TONE_H3 - 1);
      default: half_cnt = 14'h0000;
    endcase
  end

  // Divider restarts from zero when the tone is off
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 14'h0000;
    end else if (tif.tone_code == 2'h0) begin
      div_reg <= 14'h0000;
    end else if (tif.run) begin
      div_reg <= (div_reg >= half_cnt) ? 14'h0000 : div_reg + 14'h0001;
    end
  end

  // Keeps toggling in active halt; only full halt drops run
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= 1'b0;
    end else if (tif.tone_code == 2'h0) begin
      level_reg <= 1'b0;
    end else if (tif.run && div_reg >= half_cnt) begin
      level_reg <= ~level_reg;
    end
  end

  assign tif.level = level_reg;

endmodule : mcrb_tone

// file: rtl/mcrb_top.sv
// Main clock controller: core prescaler, clock-out, real-time tick, tone.
// Assumes an AHB-Lite master on the oscillator clock and CPU halt signals
// on the same clock, so none of them is synchronised.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ns
module mcrb_top
  import mcrb_pkg::*;
#(
  parameter int TICK_P0 = MCRB_TICK_P0,
  parameter int TICK_P1 = MCRB_TICK_P1,
  parameter int TICK_P2 = MCRB_TICK_P2,
  parameter int TICK_P3 = MCRB_TICK_P3,
  parameter int TONE_H3 = MCRB_TONE_H3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // CPU power and interrupt interface
  input wire logic halt_req_i,
  input wire logic irq_mask_i,
  input wire logic halt_wake_i,
  output logic tick_irq_o,
  output logic [1:0] power_state_o,
  // Clocks and pins
  output logic core_clk_en_o,
  output logic clock_out_pin_o,
  output logic clock_out_oe_o,
  output logic tone_pin_o,
  output logic tone_oe_o,
  // Block interrupt
  output logic irq_o
);

  // ************************************************************
  // Registers and bus state
  // ************************************************************
  logic clock_out_select_reg;
  logic [1:0] core_prescale_code_reg;
  logic slow_mode_select_reg;
  logic [1:0] tick_period_code_reg;
  logic tick_irq_enable_reg;
  logic tick_flag_reg;
  logic [1:0] tone_code_reg;
  logic [0:0] irq_stat_reg;
  logic [0:0] irq_mask_reg;
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [31:0] hrdata_reg;
  mcrb_pwr_t pwr_reg;
  mcrb_pwr_t pwr_next;
  logic [17:0] tick_cnt_reg;
  logic [17:0] tick_last_reg;
  logic [3:0] pre_cnt_reg;
  logic core_en_reg;
  logic clk_out_reg;
  logic clk_out_oe_reg;
  logic tone_oe_reg;
  logic tick_irq_reg;
  logic irq_reg;

  logic addr_ok;
  logic rd_acc;
  logic wr_acc;
  logic [7:0] acc_idx;
  logic frozen;
  logic tick_end;
  logic tick_wake;
  logic [17:0] tick_last_sel;
  logic [3:0] div_last;
  logic [7:0] ccs_val;

  mcrb_tone_if tif ();

  assign acc_idx = haddr_i[9:2];
  assign addr_ok = hsel_i && hready_i && htrans_i[1];
  assign rd_acc = addr_ok && !hwrite_i;
  assign wr_acc = addr_ok && hwrite_i;
  assign frozen = (pwr_reg != MCRB_RUN);
  assign tick_end = (tick_cnt_reg >= tick_last_reg);
  assign ccs_val = {clock_out_select_reg, core_prescale_code_reg, slow_mode_select_reg,
                    tick_period_code_reg, tick_irq_enable_reg, tick_flag_reg};

  // ************************************************************
  // Bus slave: zero wait states, always OKAY
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end else begin
      wr_pend_reg <= wr_acc;
      wr_idx_reg <= acc_idx;
    end
  end

  // Read data is captured in the address phase so it stands as a flop output
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_reg <= 32'h00000000;
    end else if (rd_acc) begin
      case (acc_idx)
        MCRB_IDX_CCS: hrdata_reg <= {24'h000000, ccs_val};
        MCRB_IDX_TONE: hrdata_reg <= {30'h00000000, tone_code_reg};
        MCRB_IDX_IRQ_STAT: hrdata_reg <= {31'h00000000, irq_stat_reg};
        MCRB_IDX_IRQ_MASK: hrdata_reg <= {31'h00000000, irq_mask_reg};
        default: hrdata_reg <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end
  assign hrdata_o = hrdata_reg;

  // ************************************************************
  // Control register; writes ignored while halted
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_out_select_reg <= MCRB_CCS_RST[MCRB_CCS_CLKOUT_BIT];
      core_prescale_code_reg <= MCRB_CCS_RST[MCRB_CCS_CP_LSB +: 2];
      slow_mode_select_reg <= MCRB_CCS_RST[MCRB_CCS_SMS_BIT];
      tick_period_code_reg <= MCRB_CCS_RST[MCRB_CCS_TB_LSB +: 2];
      tick_irq_enable_reg <= MCRB_CCS_RST[MCRB_CCS_IE_BIT];
    end else if (wr_pend_reg && wr_idx_reg == MCRB_IDX_CCS && !frozen) begin
      clock_out_select_reg <= hwdata_i[MCRB_CCS_CLKOUT_BIT];
      core_prescale_code_reg <= hwdata_i[MCRB_CCS_CP_LSB +: 2];
      slow_mode_select_reg <= hwdata_i[MCRB_CCS_SMS_BIT];
      tick_period_code_reg <= hwdata_i[MCRB_CCS_TB_LSB +: 2];
      tick_irq_enable_reg <= hwdata_i[MCRB_CCS_IE_BIT];
    end
  end

  // Flag bit is read-only; a read clears it but a same-cycle period end wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_flag_reg <= MCRB_CCS_RST[MCRB_CCS_FLAG_BIT];
    end else if (tick_end && pwr_reg != MCRB_FULL_HALT) begin
      tick_flag_reg <= 1'b1;
    end else if (rd_acc && acc_idx == MCRB_IDX_CCS) begin
      tick_flag_reg <= 1'b0;
    end
  end

  // Upper tone bits are not stored and read as zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tone_code_reg <= MCRB_TONE_RST;
    end else if (wr_pend_reg && wr_idx_reg == MCRB_IDX_TONE && !frozen) begin
      tone_code_reg <= hwdata_i[1:0];
    end
  end

  // ************************************************************
  // Sticky event status and mask
  // ************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= MCRB_IRQ_RST;
    end else if (tick_end && pwr_reg != MCRB_FULL_HALT) begin
      irq_stat_reg <= 1'b1;
    end else if (wr_pend_reg && wr_idx_reg == MCRB_IDX_IRQ_STAT && hwdata_i[0]) begin
      irq_stat_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_reg <= MCRB_IRQ_RST;
    end else if (wr_pend_reg && wr_idx_reg == MCRB_IDX_IRQ_MASK) begin
      irq_mask_reg <= hwdata_i[0:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end
  assign irq_o = irq_reg;

  // ************************************************************
  // Real-time tick counter
  // ************************************************************
  always_comb begin
    case (tick_period_code_reg)
      2'h0: tick_last_sel = 18'(TICK_P0 - 1);
      2'h1: tick_last_sel = 18'(TICK_P1 - 1);
      2'h2: tick_last_sel = 18'(TICK_P2 - 1);
      default: tick_last_sel = 18'(TICK_P3 - 1);
    endcase
  end

  // Period length is latched only at a period end, so a code change never
  // shortens or stretches the period in progress
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= 18'h00000;
      tick_last_reg <= 18'(TICK_P0 - 1);
    end else if (pwr_reg != MCRB_FULL_HALT) begin
      if (tick_end) begin
        tick_cnt_reg <= 18'h00000;
        tick_last_reg <= tick_last_sel;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 18'h00001;
      end
    end
  end

  // Request reaches the CPU only when enabled and not globally masked
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_irq_reg <= 1'b0;
    end else begin
      tick_irq_reg <= tick_flag_reg && tick_irq_enable_reg && !irq_mask_i;
    end
  end
  assign tick_irq_o = tick_irq_reg;

  // ************************************************************
  // Power state
  // ************************************************************
  // Wakes active halt regardless of the global mask; wait exit is the CPU's
  assign tick_wake = tick_flag_reg && tick_irq_enable_reg;

  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      MCRB_RUN: begin
        if (halt_req_i) begin
          pwr_next = tick_irq_enable_reg ? MCRB_ACT_HALT : MCRB_FULL_HALT;
        end
      end
      MCRB_ACT_HALT: begin
        if (tick_wake || halt_wake_i) begin
          pwr_next = MCRB_RUN;
        end
      end
      MCRB_FULL_HALT: begin
        if (halt_wake_i) begin
          pwr_next = MCRB_RUN;
        end
      end
      default: pwr_next = MCRB_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_reg <= MCRB_RUN;
    end else begin
      pwr_reg <= pwr_next;
    end
  end
  assign power_state_o = pwr_reg;

  // ************************************************************
  // Core clock prescaler and clock-out
  // ************************************************************
  always_comb begin
    if (!slow_mode_select_reg) begin
      div_last = 4'h0;
    end else begin
      case (core_prescale_code_reg)
        2'h0: div_last = 4'h1;
        2'h1: div_last = 4'h3;
        2'h2: div_last = 4'h7;
        default: div_last = 4'hf;
      endcase
    end
  end

  // Core clock is given as an enable; it stops in either halt
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt_reg <= 4'h0;
      core_en_reg <= 1'b0;
    end else if (frozen) begin
      core_en_reg <= 1'b0;
    end else begin
      pre_cnt_reg <= (pre_cnt_reg >= div_last) ? 4'h0 : pre_cnt_reg + 4'h1;
      core_en_reg <= (pre_cnt_reg >= div_last);
    end
  end
  assign core_clk_en_o = core_en_reg;

  // Pin toggles on each core enable, so it shows half the core rate; a flop
  // output cannot carry the undivided oscillator
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_out_reg <= 1'b0;
      clk_out_oe_reg <= 1'b0;
    end else begin
      clk_out_oe_reg <= clock_out_select_reg && pwr_reg != MCRB_ACT_HALT;
      if (!clock_out_select_reg || pwr_reg == MCRB_ACT_HALT) begin
        clk_out_reg <= 1'b0;
      end else if (core_en_reg) begin
        clk_out_reg <= ~clk_out_reg;
      end
    end
  end
  assign clock_out_pin_o = clk_out_reg;
  assign clock_out_oe_o = clk_out_oe_reg;

  // ************************************************************
  // Tone
  // ************************************************************
  assign tif.tone_code = tone_code_reg;
  assign tif.run = (pwr_reg != MCRB_FULL_HALT);

  mcrb_tone #(
    .TONE_H3(TONE_H3)
  ) u_tone (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tif(tif)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tone_oe_reg <= 1'b0;
    end else begin
      tone_oe_reg <= (tone_code_reg != 2'h0);
    end
  end
  assign tone_pin_o = tif.level;
  assign tone_oe_o = tone_oe_reg;

endmodule : mcrb_top

// file: bench/mcrb_top_props.sv
// Checker for the clock, tick and tone block, on the top-level ports only.
// Assumes the single oscillator clock and the active-low asynchronous reset.
`timescale 1ns/1ns
module mcrb_top_props
  import mcrb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // CPU side
  input wire logic halt_req_i,
  input wire logic halt_wake_i,
  input wire logic irq_mask_i,
  input wire logic tick_irq_o,
  input wire logic [1:0] power_state_o,
  // Clocks and pins
  input wire logic core_clk_en_o,
  input wire logic clock_out_pin_o,
  input wire logic clock_out_oe_o,
  input wire logic tone_pin_o,
  input wire logic tone_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ************************************************************
  // Sequences and properties
  // ************************************************************
  sequence s_act_halt;
    power_state_o == MCRB_ACT_HALT [*2];
  endsequence
  sequence s_tone_edge;
    tone_oe_o && $changed(tone_pin_o);
  endsequence
  property p_clkout_suspend;
    s_act_halt |-> !clock_out_oe_o && !clock_out_pin_o;
  endproperty
  property p_clkout_idle;
    !clock_out_oe_o [*2] |-> !clock_out_pin_o;
  endproperty
  // Slowest core clock is one enable in 16 cycles
  property p_core_gap;
    $fell(core_clk_en_o) && power_state_o == MCRB_RUN
      |-> ##[1:15] (core_clk_en_o || power_state_o != MCRB_RUN);
  endproperty
  property p_halt_gate;
    power_state_o != MCRB_RUN [*2] |-> !core_clk_en_o;
  endproperty
  property p_halt_entry;
    power_state_o == MCRB_RUN && halt_req_i |=> power_state_o != MCRB_RUN;
  endproperty
  property p_full_hold;
    power_state_o == MCRB_FULL_HALT && !halt_wake_i |=> power_state_o == MCRB_FULL_HALT;
  endproperty
  property p_full_exit;
    power_state_o != MCRB_RUN && halt_wake_i |-> ##[1:2] power_state_o == MCRB_RUN;
  endproperty
  property p_tick_mask;
    tick_irq_o |-> !$past(irq_mask_i);
  endproperty
  property p_tone_off;
    !tone_oe_o [*2] |-> !tone_pin_o;
  endproperty
  property p_tone_hold;
    s_tone_edge ##1 tone_oe_o |-> $stable(tone_pin_o);
  endproperty

  // ************************************************************
  // Assertions
  // ************************************************************
  a_clkout_suspend: assert property (p_clkout_suspend)
    else $error("clock-out active in active halt");
  a_clkout_idle: assert property (p_clkout_idle)
    else $error("clock-out pin moves while deselected");
  a_core_gap: assert property (p_core_gap)
    else $error("core enable gap longer than 16");
  a_halt_gate: assert property (p_halt_gate)
    else $error("core enable in halt");
  a_halt_entry: assert property (p_halt_entry)
    else $error("halt request ignored");
  a_full_hold: assert property (p_full_hold)
    else $error("full halt left without wakeup");
  a_full_exit: assert property (p_full_exit)
    else $error("wakeup did not end halt");
  a_tick_mask: assert property (p_tick_mask)
    else $error("tick interrupt while globally masked");
  a_tone_off: assert property (p_tone_off)
    else $error("tone pin high while off");
  a_tone_hold: assert property (p_tone_hold)
    else $error("tone pin toggled twice in a row");
endmodule : mcrb_top_props

bind mcrb_top mcrb_top_props mcrb_top_props_inst (.*);

// file: bench/tb.sv
// Self-checking bench for the clock, tick and tone block.
// Assumes a zero-wait AHB-Lite slave and shortened tick periods.
`timescale 1ns/1ns
module tb;
  import mcrb_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  localparam int P [4] = '{20, 30, 40, 3000};
  localparam int HT = 6000;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = '0;
  logic [1:0] htrans_i = '0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = '0;
  logic hready_i, hreadyout_o, hresp_o, tick_irq_o, core_clk_en_o, irq_o;
  logic clock_out_pin_o, clock_out_oe_o, tone_pin_o, tone_oe_o, lv;
  logic halt_req_i = 1'b0;
  logic irq_mask_i = 1'b0;
  logic halt_wake_i = 1'b0;
  logic [1:0] power_state_o;
  logic [31:0] hrdata_o, rd;
  int err_total = 0;
  int comparisons = 0;
  int cyc, t0, t1, n;
  `define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin err_total++; \
    $display("BAD %0t %s", $time, m); end end

  assign hready_i = hreadyout_o;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i or negedge rst_n_i) cyc <= rst_n_i ? cyc + 1 : 0;

  mcrb_top #(.TICK_P0(P[0]), .TICK_P1(P[1]), .TICK_P2(P[2]), .TICK_P3(P[3]), .TONE_H3(HT))
    mcrb_top_inst (.*);

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    rd = hrdata_o;
  endtask : bus

  task automatic wait_irq(output int t);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (irq_o !== 1'b1 && n < 4000);
    `CHK(irq_o, 1'b1, "no tick event")
    t = cyc;
  endtask : wait_irq

  task automatic wait_tgl(output int t);
    n = 0;
    lv = tone_pin_o;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (tone_pin_o === lv && n < 10000);
    t = cyc;
  endtask : wait_tgl

  task automatic halt_pulse;
    @(posedge clk_i);
    halt_req_i <= 1'b1;
    @(posedge clk_i);
    halt_req_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : halt_pulse

  task automatic stop_test;
    $display("Mismatches %0d of %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #(90000 * 100);
    err_total++;
    stop_test();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b1, 32'hbc, 32'h1);
    // Catch the first tick before other traffic, so its edge is exact
    wait_irq(t0);
    `CHK(t0, P[0] + 1, "first period after reset")
    bus(1'b0, 32'hb0, '0);
    `CHK(rd, 32'h1, "flag not set")
    bus(1'b0, 32'hb0, '0);
    `CHK(rd, 32'h0, "flag not cleared by read")
    bus(1'b1, 32'hb8, 32'h1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 32'hb0, 32'((i + 1) % 4) << 2);
      wait_irq(t1);
      `CHK(t1 - t0, P[i], "old period not finished")
      bus(1'b1, 32'hb8, 32'h1);
      wait_irq(t0);
      `CHK(t0 - t1, P[(i + 1) % 4], "tick period")
      bus(1'b1, 32'hb8, 32'h1);
    end
    bus(1'b0, 32'hb4, '0);
    `CHK(rd, 32'h0, "tone reset value")
    bus(1'b0, 32'hc0, '0);
    `CHK(rd, 32'h0, "unmapped read")
    `CHK(hresp_o, 1'b0, "bus response not OKAY")
    bus(1'b0, 32'hbc, '0);
    `CHK(rd, 32'h1, "mask readback")
    irq_mask_i <= 1'b1;
    bus(1'b1, 32'hb0, 32'h2);
    repeat (45) @(posedge clk_i);
    #1;
    `CHK(tick_irq_o, 1'b0, "tick irq while masked")
    @(posedge clk_i);
    irq_mask_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(tick_irq_o, 1'b1, "tick irq missing")
    bus(1'b1, 32'hbc, 32'h0);
    repeat (45) @(posedge clk_i);
    #1;
    `CHK(irq_o, 1'b0, "block irq while masked")
    bus(1'b1, 32'hbc, 32'h1);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(irq_o, 1'b1, "block irq missing")
    for (int c = 0; c < 5; c++) begin
      bus(1'b1, 32'hb0, c < 4 ? 32'h90 | (32'(c) << 5) : 32'h80);
      repeat (4) @(posedge clk_i);
      #1;
      n = 0;
      t1 = 0;
      lv = clock_out_pin_o;
      repeat (64) begin
        @(posedge clk_i);
        #1;
        n += int'(core_clk_en_o === 1'b1);
        t1 += int'(clock_out_pin_o !== lv);
        lv = clock_out_pin_o;
      end
      `CHK(n, c < 4 ? 32 >> c : 64, "core clock rate")
      `CHK(t1, c < 4 ? 32 >> c : 64, "clock-out rate")
      `CHK(clock_out_oe_o, 1'b1, "clock-out not driven")
    end
    for (int c = 1; c < 4; c++) begin
      bus(1'b1, 32'hb4, 32'(c));
      wait_tgl(t0);
      wait_tgl(t1);
      `CHK(t1 - t0, c == 1 ? MCRB_TONE_H1 : c == 2 ? MCRB_TONE_H2 : HT, "tone")
      `CHK(tone_oe_o, 1'b1, "tone pin not driven")
    end
    bus(1'b1, 32'hb4, 32'h0);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK({tone_oe_o, tone_pin_o}, 2'b00, "tone not off")
    // Long period keeps active halt open past one tone half period
    bus(1'b1, 32'hb4, 32'h1);
    bus(1'b1, 32'hb0, 32'h8e);
    bus(1'b1, 32'hb8, 32'h1);
    wait_irq(t0);
    bus(1'b0, 32'hb0, '0);
    bus(1'b1, 32'hb8, 32'h1);
    halt_pulse();
    `CHK(power_state_o, MCRB_ACT_HALT, "no active halt")
    repeat (2) @(posedge clk_i);
    #1;
    `CHK({clock_out_oe_o, clock_out_pin_o}, 2'b00, "clock-out in halt")
    wait_tgl(t1);
    `CHK(power_state_o, MCRB_ACT_HALT, "tone stopped in active halt")
    n = 0;
    while (power_state_o !== MCRB_RUN && n < 4000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK(power_state_o, MCRB_RUN, "tick did not wake")
    bus(1'b1, 32'hb0, 32'h80);
    bus(1'b1, 32'hb8, 32'h1);
    wait_irq(t0);
    bus(1'b1, 32'hb8, 32'h1);
    halt_pulse();
    `CHK(power_state_o, MCRB_FULL_HALT, "no full halt")
    repeat (100) @(posedge clk_i);
    #1;
    `CHK(irq_o, 1'b0, "tick counted in full halt")
    `CHK(power_state_o, MCRB_FULL_HALT, "full halt left")
    @(posedge clk_i);
    halt_wake_i <= 1'b1;
    @(posedge clk_i);
    halt_wake_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(power_state_o, MCRB_RUN, "wakeup ignored")
    stop_test();
  end
endmodule : tb
